/* File: rtl/periph_clock_gating.v */
/*
 Peripheral clock gating: clock-enable and stop-keep registers, write
 protection and per-peripheral gated clocks with stop-mode control.
 Assumes stop_req is a level from the same clock domain and that the
 register master follows the one-cycle strobe port.
*/
// Operation
// (R1) Gated-off peripheral is in stop mode
// (R2) Access to gated peripheral has no effect
// (R3) Stop gates enabled clock unless keep set
// (R4) Keep bit runs clock only while enabled
// (R5) Bits 15,14 gate comparators B and A
// (R6) Bits 13,12 gate both converters
// (R7) Bit 10 gates the ADC clock
// (R8) Bit 6 gates I2C bus clock
// (R9) Bits 4,2 gate serial and SPI
// (R10) Bit 0 gates the PWM clock
// (R11) Second register bits 14..12 gate interval timers
// (R12) Second register bits 3..0 gate timer channels
// (R13) Software writes zeros to reserved bits
// (R14) Keep-A bits match enable-A positions
// (R15) Kept peripherals may wake system with interrupt
// (R16) All enable and keep bits reset to zero
// (R17) Software disables peripheral before gating it
// (R18) Keep-B bits match enable-B, need enable
// (R19) Two-bit protect field with reset-only lock
// (R20) Leaving stop follows enables, glitch-free
`include "clk_gate_map.vh"

module periph_clock_gating
(
   input  wire        clk,
   input  wire        rst_n,
   input  wire [4:0]  addr,
   input  wire [15:0] wdata,
   input  wire        wr,
   input  wire        rd,
   output reg  [15:0] rdata,
   input  wire        stop_req,
   input  wire [15:0] periph_irq,
   output wire        wake_irq,
   output wire        run_mode,
   output wire [15:0] periph_run_a,
   output wire [15:0] periph_run_b,
   output wire [15:0] periph_access_a,
   output wire [15:0] periph_access_b,
   output wire [15:0] gclk_a,
   output wire [15:0] gclk_b
);
   localparam [1:0] ST_RUN  = 2'b01;
   localparam [1:0] ST_STOP = 2'b10;

   wire [15:0] en_a_q;
   wire [15:0] en_b_q;
   wire [15:0] keep_a_q;
   wire [15:0] keep_b_q;
   reg  [1:0]  prot_q;
   reg         prot_lock_q;
   reg  [1:0]  state_q;
   reg  [1:0]  state_d;
   reg  [15:0] run_a_q;
   reg  [15:0] run_b_q;
   wire        prot_on;
   wire        stop_now;
   wire [15:0] run_a_d;
   wire [15:0] run_b_d;

   // Enables pass only kept bits in stop, through the keep masks
   function [15:0] run_mask;
      input [15:0] en;
      input [15:0] keep;
      input        stopped;
      begin
         run_mask = stopped ? (en & keep) : en; // R3 R4 R18 R20
      end
   endfunction

   function hit;
      input [4:0] a;
      input [4:0] ofs;
      begin
         hit = (a == ofs);
      end
   endfunction

   assign prot_on = prot_q[0]; // R19
   wire   wr_ok   = wr & ~prot_on;

   // Reserved bits are dropped by the masks; software should write zero
   masked_reg #(.MASK(`MASK_A)) u_en_a // R5 R6 R7 R8 R9 R10 R16
   (
      .clk   (clk),
      .rst_n (rst_n),
      .we    (wr_ok & hit(addr, `OFS_CLK_EN_A)),
      .wdata (wdata),
      .q     (en_a_q)
   );

   masked_reg #(.MASK(`MASK_B)) u_en_b // R11 R12 R16
   (
      .clk   (clk),
      .rst_n (rst_n),
      .we    (wr_ok & hit(addr, `OFS_CLK_EN_B)),
      .wdata (wdata),
      .q     (en_b_q)
   );

   masked_reg #(.MASK(`MASK_A)) u_keep_a // R14 R16
   (
      .clk   (clk),
      .rst_n (rst_n),
      .we    (wr_ok & hit(addr, `OFS_STOP_KEEP_A)),
      .wdata (wdata),
      .q     (keep_a_q)
   );

   masked_reg #(.MASK(`MASK_B)) u_keep_b // R18 R16
   (
      .clk   (clk),
      .rst_n (rst_n),
      .we    (wr_ok & hit(addr, `OFS_STOP_KEEP_B)),
      .wdata (wdata),
      .q     (keep_b_q)
   );

   // Lock bit freezes the field until reset
   always @(posedge clk)
   begin
      if (!rst_n)
      begin
         prot_q      <= `RESET_PROT;
         prot_lock_q <= 1'b0;
      end
      else if (wr && hit(addr, `OFS_WRITE_PROTECT) && !prot_lock_q)
      begin
         prot_q      <= wdata[`PROT_MSB:`PROT_LSB]; // R19
         prot_lock_q <= wdata[`PROT_MSB];
      end
   end

   // Any unmasked interrupt from a running peripheral ends stop mode
   assign wake_irq = |(periph_irq & (run_a_q | run_b_q)); // R15

   always @*
   begin
      state_d = state_q;
      case (state_q)
         ST_RUN:
         begin
            if (stop_req && !wake_irq)
               state_d = ST_STOP;
         end
         ST_STOP:
         begin
            if (wake_irq || !stop_req)
               state_d = ST_RUN; // R15 R20
         end
         default:
            state_d = ST_RUN;
      endcase
   end

   always @(posedge clk)
   begin
      if (!rst_n)
         state_q <= ST_RUN;
      else
         state_q <= state_d;
   end

   assign stop_now = (state_q == ST_STOP);
   assign run_mode = (state_q == ST_RUN);
   assign run_a_d  = run_mask(en_a_q, keep_a_q, stop_now);
   assign run_b_d  = run_mask(en_b_q, keep_b_q, stop_now);

   // Registered enables so gate cells see a clean synchronous level
   always @(posedge clk)
   begin
      if (!rst_n)
      begin
         run_a_q <= `RESET_REG;
         run_b_q <= `RESET_REG;
      end
      else
      begin
         run_a_q <= run_a_d; // R1 R3
         run_b_q <= run_b_d;
      end
   end

   assign periph_run_a    = run_a_q; // R1
   assign periph_run_b    = run_b_q;
   // Peripheral bus select is blocked while its clock is off
   assign periph_access_a = run_a_q; // R2
   assign periph_access_b = run_b_q; // R2

   genvar i;
   generate
      for (i = 0; i < 16; i = i + 1)
      begin : g_gate
         gate_cell u_ga
         (
            .clk  (clk),
            .en   (run_a_q[i]),
            .gclk (gclk_a[i])
         );
         gate_cell u_gb
         (
            .clk  (clk),
            .en   (run_b_q[i]),
            .gclk (gclk_b[i])
         );
      end
   endgenerate

   // Unmapped addresses read zero
   always @(posedge clk)
   begin
      if (!rst_n)
         rdata <= 16'h0000;
      else if (rd)
      begin
         case (addr)
            `OFS_CLK_EN_A:      rdata <= en_a_q;
            `OFS_CLK_EN_B:      rdata <= en_b_q;
            `OFS_STOP_KEEP_A:   rdata <= keep_a_q;
            `OFS_STOP_KEEP_B:   rdata <= keep_b_q;
            `OFS_WRITE_PROTECT: rdata <= {12'h000, prot_q, 2'b00};
            default:            rdata <= 16'h0000;
         endcase
      end
      else
         rdata <= 16'h0000;
   end
endmodule

/* File: rtl/clk_gate_map.vh */
/*
 Register offsets, field positions, masks and reset values of the
 peripheral clock gating block. Assumes 16-bit register data and a
 word-indexed register port.
*/
`ifndef CLK_GATE_MAP_VH
`define CLK_GATE_MAP_VH

`define ADDR_W               5
`define DATA_W               16
`define OFS_CLK_EN_A         5'h0C
`define OFS_CLK_EN_B         5'h0D
`define OFS_STOP_KEEP_A      5'h0E
`define OFS_STOP_KEEP_B      5'h0F
`define OFS_WRITE_PROTECT    5'h12

`define MASK_A               16'hF455
`define MASK_B               16'h700F
`define RESET_REG            16'h0000
`define RESET_PROT           2'b00

`define BIT_CMP_B            15
`define BIT_CMP_A            14
`define BIT_DAC_ONE          13
`define BIT_DAC_ZERO         12
`define BIT_ADC              10
`define BIT_I2C              6
`define BIT_ASYNC_SERIAL     4
`define BIT_SPI_PORT         2
`define BIT_PWM              0
`define BIT_TIMER2           14
`define BIT_TIMER1           13
`define BIT_TIMER0           12
`define BIT_TIMER_CH3        3
`define BIT_TIMER_CH0        0
`define PROT_LSB             2
`define PROT_MSB             3

`endif

/* File: rtl/gate_cell.v */
/*
 Glitch-free clock gate for one peripheral: enable captured on the falling
 edge, ANDed with the clock. Assumes enable is synchronous to clk.
*/
module gate_cell
(
   input  wire clk,
   input  wire en,
   output wire gclk
);
   reg en_lat;

   // Enable changes only while clk is low, so no gated pulse is cut short
   always @(negedge clk)
   begin
      en_lat <= en;
   end

   assign gclk = clk & en_lat;
endmodule

/* File: rtl/masked_reg.v */
/*
 One 16-bit control register with a fixed writable-bit mask. Reserved
 bits hold zero. Assumes write enable already qualified by protection.
*/
`include "clk_gate_map.vh"

module masked_reg
#(
   parameter [15:0] MASK = 16'hFFFF
)
(
   input  wire        clk,
   input  wire        rst_n,
   input  wire        we,
   input  wire [15:0] wdata,
   output reg  [15:0] q
);
   always @(posedge clk)
   begin
      if (!rst_n)
         q <= `RESET_REG;
      else if (we)
         q <= wdata & MASK;
   end
endmodule

/* File: test/pcg_chk.sv */
/*
 Port checker for the clock gating block.
 Assumes the register map header is on the include path.
*/
`include "clk_gate_map.vh"
module pcg_chk
(
   input logic        clk,
   input logic        rst_n,
   input logic [4:0]  addr,
   input logic        rd,
   input logic [15:0] rdata,
   input logic        stop_req,
   input logic [15:0] periph_irq,
   input logic        wake_irq,
   input logic        run_mode,
   input logic [15:0] periph_run_a,
   input logic [15:0] periph_run_b,
   input logic [15:0] periph_access_a,
   input logic [15:0] periph_access_b
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   sequence s_rd_a;
      rd && run_mode && addr == `OFS_CLK_EN_A;
   endsequence
   sequence s_enter;
      run_mode && stop_req && !wake_irq;
   endsequence
   AST_RD_A: assert property (s_rd_a |=> rdata == periph_run_a)
      else $error("enable readback differs from running clocks");
   AST_MASK_A: assert property ((periph_run_a & ~`MASK_A) == 16'h0000)
      else $error("reserved clock A running");
   AST_MASK_B: assert property ((periph_run_b & ~`MASK_B) == 16'h0000)
      else $error("reserved clock B running");
   AST_ACC_A: assert property (periph_access_a == periph_run_a)
      else $error("access A without clock");
   AST_ACC_B: assert property (periph_access_b == periph_run_b)
      else $error("access B without clock");
   AST_WAKE: assert property
      (wake_irq == |(periph_irq & (periph_run_a | periph_run_b)))
      else $error("wake does not follow clocked interrupts");
   AST_ENTER: assert property (s_enter |=> !run_mode)
      else $error("stop not entered");
   AST_EXIT: assert property (!run_mode && (!stop_req || wake_irq) |=> run_mode)
      else $error("stop not left");
   AST_SHRINK: assert property
      ($fell(run_mode) |=> (periph_run_a & ~$past(periph_run_a)) == 16'h0000)
      else $error("clock started on stop entry");
endmodule
bind periph_clock_gating pcg_chk u_chk (.clk(clk), .rst_n(rst_n), .addr(addr), .rd(rd),
   .rdata(rdata), .stop_req(stop_req), .periph_irq(periph_irq), .wake_irq(wake_irq),
   .run_mode(run_mode), .periph_run_a(periph_run_a), .periph_run_b(periph_run_b),
   .periph_access_a(periph_access_a), .periph_access_b(periph_access_b));

/* File: test/periph_model.sv */
/*
 Peripheral side: each peripheral flags its interrupt level.
 Assumes req comes from the bench on the system clock.
*/
module periph_model
(
   input  logic        clk,
   input  logic [15:0] periph_run_a,
   input  logic [15:0] periph_run_b,
   input  logic [15:0] req,
   output logic [15:0] periph_irq = 16'h0000
);
   timeunit 1ns;
   timeprecision 1ps;
   // An unclocked peripheral cannot flag anything
   always @(posedge clk)
   begin
      periph_irq <= req & (periph_run_a | periph_run_b);
   end
endmodule

/* File: test/tb_top.sv */
/*
 Self-checking bench for the clock gating block.
 Assumes the register map header is on the include path.
*/
`include "clk_gate_map.vh"
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk = 1'h0;
   logic        rst_n = 1'h0;
   logic [4:0]  addr = 5'h00;
   logic [15:0] wdata = 16'h0000;
   logic        wr = 1'h0;
   logic        rd = 1'h0;
   logic        stop_req = 1'h0;
   logic [15:0] req = 16'h0000;
   logic [15:0] rdata, irq, run_a, run_b, gclk_a, gclk_b;
   logic        wake_irq, run_mode;
   int          mismatches = 0;
   int          samples_checked = 0;
   periph_clock_gating DUT (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
      .wr(wr), .rd(rd), .rdata(rdata), .stop_req(stop_req), .periph_irq(irq),
      .wake_irq(wake_irq), .run_mode(run_mode), .periph_run_a(run_a), .periph_run_b(run_b),
      .periph_access_a(), .periph_access_b(), .gclk_a(gclk_a), .gclk_b(gclk_b));
   periph_model u_far (.clk(clk), .periph_run_a(run_a), .periph_run_b(run_b), .req(req),
      .periph_irq(irq));
   initial
   begin
      forever #5 clk = ~clk;
   end
   task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         mismatches++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic wreg(input logic [4:0] a, input logic [15:0] d);
      @(posedge clk);
      wr <= 1'h1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr <= 1'h0;
   endtask
   task automatic rreg(input logic [4:0] a, input logic [15:0] e);
      @(posedge clk);
      rd <= 1'h1;
      addr <= a;
      @(posedge clk);
      rd <= 1'h0;
      #1 cmp(rdata, e);
   endtask
   task automatic do_reset;
      @(posedge clk);
      rst_n <= 1'h0;
      repeat (20) @(posedge clk);
      rst_n <= 1'h1;
   endtask
   task automatic t_reset;
      do_reset();
      rreg(`OFS_CLK_EN_A, 16'h0000);
      rreg(`OFS_STOP_KEEP_A, 16'h0000);
      cmp(run_a | run_b, 16'h0000);
   endtask
   task automatic t_enable;
      wreg(`OFS_CLK_EN_A, 16'hFFFF);
      wreg(`OFS_CLK_EN_B, 16'hFFFF);
      rreg(`OFS_CLK_EN_A, 16'hF455);
      rreg(`OFS_CLK_EN_B, 16'h700F);
      cmp(gclk_a, 16'hF455);
      cmp(gclk_b, 16'h700F);
      wreg(5'h01, 16'hFFFF);
      rreg(5'h01, 16'h0000);
   endtask
   task automatic t_stop;
      wreg(`OFS_CLK_EN_A, 16'h0011);
      wreg(`OFS_STOP_KEEP_A, 16'h0005);
      wreg(`OFS_STOP_KEEP_B, 16'h1001);
      stop_req <= 1'h1;
      tick(4);
      cmp({15'h0000, run_mode}, 16'h0000);
      cmp(run_a, 16'h0001);
      cmp(run_b, 16'h1001);
      cmp(gclk_a, 16'h0001);
      req <= 16'h0010;
      tick(4);
      cmp({15'h0000, run_mode}, 16'h0000);
      req <= 16'h0001;
      tick(4);
      cmp({15'h0000, run_mode}, 16'h0001);
      cmp(run_a, 16'h0011);
      req <= 16'h0000;
      stop_req <= 1'h0;
   endtask
   task automatic t_protect;
      wreg(`OFS_WRITE_PROTECT, 16'h0004);
      wreg(`OFS_CLK_EN_A, 16'h0000);
      rreg(`OFS_CLK_EN_A, 16'h0011);
      wreg(`OFS_WRITE_PROTECT, 16'h0008);
      wreg(`OFS_WRITE_PROTECT, 16'h0004);
      wreg(`OFS_CLK_EN_A, 16'h0000);
      rreg(`OFS_CLK_EN_A, 16'h0000);
      rreg(`OFS_WRITE_PROTECT, 16'h0008);
      do_reset();
      rreg(`OFS_WRITE_PROTECT, 16'h0000);
   endtask
   task automatic summarize;
      if (mismatches == 0 && samples_checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   initial
   begin
      t_reset();
      t_enable();
      t_stop();
      t_protect();
      summarize();
   end
   // Whole run is about a hundred cycles; this only cuts a hang
   initial
   begin
      #100000;
      mismatches++;
      summarize();
   end
endmodule
